// *** rtl/lcd_timing_regs.svh ***
// Register offsets, field positions, reset values and widths of the panel clock block.
// Assumes APB byte addressing with one aligned 32-bit word per register.
`ifndef LCD_TIMING_REGS_SVH
`define LCD_TIMING_REGS_SVH

// ======================================================================
// Register offsets
`define OFS_MODE_CTRL      8'h00
`define OFS_STATUS         8'h04
`define OFS_PANEL_PANEL_TIMING_SECOND  8'h08

// ======================================================================
// Second timing register fields
`define T2_BYPASS_BIT      26
`define T2_FP_INV_BIT      11
`define T2_BIAS_MSB        10
`define T2_BIAS_LSB        6
`define T2_CLK_SRC_BIT     5
`define T2_DIV_MSB         4
`define T2_DIV_LSB         0
`define T2_LP_INV_BIT      12
`define T2_OE_INV_BIT      14
`define T2_WRITE_MASK      32'h07FF_7FFF
`define T2_RESET           32'h0000_0000

// ======================================================================
// Mode control fields
`define MC_TFT_BIT         0
`define MC_COLOUR_BIT      1
`define MC_WRITE_MASK      32'h0000_0003
`define MC_RESET           32'h0000_0000

// ======================================================================
// Divider and packing sizes
`define DIV_OFFSET         6'h02
`define PIXELS_PER_GROUP   4'h8
`define BYTES_PER_GROUP    2'h3

`endif

// *** rtl/lcd_timing_pkg.sv ***
// Types shared by the panel clock and polarity block.
// Assumes the constants come from lcd_timing_regs.svh.
package lcd_timing_pkg;

    typedef enum logic [1:0] {
        PACK_FILL = 2'b01,
        PACK_SEND = 2'b10
    } pack_state_t;

    typedef logic [4:0] divisor_t;

endpackage

// *** rtl/panel_clock_divider.sv ***
// Panel clock divider: divides controller clock ticks by (divisor + 2), or bypasses.
// Assumes i_tick is a one-cycle enable marking each controller clock period.
`timescale 1ns/1ps
`include "lcd_timing_regs.svh"

module panel_clock_divider
    import lcd_timing_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rst,
    input  wire logic     i_tick,
    input  wire divisor_t i_divisor,
    input  wire logic     i_bypass,
    output logic          o_panel_clk,
    output logic          o_rise
);

    // ==================================================================
    // Period arithmetic
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [5:0] period;
    logic [5:0] half;
    logic       wrap;
    logic       clk_d;

    assign period = {1'b0, i_divisor} + `DIV_OFFSET;
    assign half   = period >> 1;
    // A divisor rewritten mid-period can leave the count above the new end.
    assign wrap   = (cnt_q >= period - 6'h01);
    assign cnt_d  = wrap ? 6'h00 : cnt_q + 6'h01;
    assign clk_d  = i_bypass ? ~o_panel_clk : (cnt_d < half);

    // ==================================================================
    // State
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q       <= 6'h00;
            o_panel_clk <= 1'b0;
            o_rise      <= 1'b0;
        end else begin
            o_rise <= i_tick & clk_d & ~o_panel_clk;
            if (i_tick) begin
                cnt_q       <= i_bypass ? 6'h00 : cnt_d;
                o_panel_clk <= clk_d;
            end
        end
    end

endmodule

// *** rtl/lcd_panel_clock_and_polarity.sv ***
// Panel clock, frame and line polarity, AC bias and colour STN byte packing.
// Assumes frame, line and data-enable timing come in as synchronous pulses
// from the rest of the display controller, and an APB master drives the bus.
`timescale 1ns/1ps
`include "lcd_timing_regs.svh"

module lcd_panel_clock_and_polarity
    import lcd_timing_pkg::*;
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_EXTERNAL_CLOCK_IN,
    input  wire logic        I_FRAME_PULSE,
    input  wire logic        I_LINE_PULSE,
    input  wire logic        I_DATA_ENABLE,
    input  wire logic [2:0]  I_PIXEL,
    input  wire logic        I_PIXEL_VALID,
    output logic             O_PIXEL_READY,
    output logic             O_FRAME_PULSE_OUT,
    output logic             O_LINE_PULSE_OUT,
    output logic             O_BIAS_OR_DATA_ENABLE_OUT,
    output logic             O_PANEL_CLOCK_OUT,
    output logic [7:0]       O_PANEL_DATA,
    output logic             O_PANEL_DATA_VALID
);

    // ==================================================================
    // APB decode
    logic [31:0] panel_timing_second_q;
    logic [31:0] mode_q;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    logic        access;
    logic        hit_mode;
    logic        hit_status;
    logic        hit_panel_timing_second;
    logic        mapped;
    logic        wr_en;

    // The slave inserts one wait state so the answer comes from flops.
    assign access      = I_PSEL & I_PENABLE & ~O_PREADY;
    assign hit_mode    = (I_PADDR == `OFS_MODE_CTRL);
    assign hit_status  = (I_PADDR == `OFS_STATUS);
    assign hit_panel_timing_second = (I_PADDR == `OFS_PANEL_PANEL_TIMING_SECOND);
    assign mapped      = hit_mode | hit_status | hit_panel_timing_second;
    assign wr_en       = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & ~O_PSLVERR;
    assign rd_mux      = hit_panel_timing_second ? panel_timing_second_q :
                         hit_mode    ? mode_q    :
                         hit_status  ? status_word : 32'h0000_0000;

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
        end else begin
            O_PREADY  <= access;
            O_PSLVERR <= access & (~mapped | (hit_status & I_PWRITE));
            if (access & ~I_PWRITE) begin
                O_PRDATA <= rd_mux;
            end
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            panel_timing_second_q <= `T2_RESET;
            mode_q    <= `MC_RESET;
        end else if (wr_en) begin
            if (hit_panel_timing_second) begin
                panel_timing_second_q <= I_PWDATA & `T2_WRITE_MASK;
            end
            if (hit_mode) begin
                mode_q <= I_PWDATA & `MC_WRITE_MASK;
            end
        end
    end

    logic     tft_mode;
    logic     colour_stn;
    logic     fp_invert;
    logic     lp_invert;
    logic     oe_invert;
    logic     ext_select;
    logic     bypass;
    logic [4:0] bias_period;
    divisor_t divisor;

    assign tft_mode    = mode_q[`MC_TFT_BIT];
    assign colour_stn  = mode_q[`MC_COLOUR_BIT] & ~tft_mode;
    assign fp_invert   = panel_timing_second_q[`T2_FP_INV_BIT];
    assign lp_invert   = panel_timing_second_q[`T2_LP_INV_BIT];
    assign oe_invert   = panel_timing_second_q[`T2_OE_INV_BIT] & tft_mode;
    assign ext_select  = panel_timing_second_q[`T2_CLK_SRC_BIT];
    assign bias_period = panel_timing_second_q[`T2_BIAS_MSB:`T2_BIAS_LSB];
    assign divisor     = panel_timing_second_q[`T2_DIV_MSB:`T2_DIV_LSB];
    // Bypass only has meaning for TFT panels; STN keeps its divider.
    assign bypass      = panel_timing_second_q[`T2_BYPASS_BIT] & tft_mode;

    // ==================================================================
    // Controller clock selection and panel clock
    logic ext_q;
    logic ctrl_tick;
    logic panel_clk;
    logic panel_rise;

    // The external pin is sampled; each rising edge is one controller tick.
    assign ctrl_tick = ext_select ? (I_EXTERNAL_CLOCK_IN & ~ext_q) : 1'b1;

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= I_EXTERNAL_CLOCK_IN;
        end
    end

    panel_clock_divider u_div (
        .i_clk       (I_CLOCK),
        .i_rst       (I_SYS_RST),
        .i_tick      (ctrl_tick),
        .i_divisor   (divisor),
        .i_bypass    (bypass),
        .o_panel_clk (panel_clk),
        .o_rise      (panel_rise)
    );

    // ==================================================================
    // AC bias and polarity outputs
    logic [4:0] line_cnt_q;
    logic       bias_q;
    logic       bias_due;

    assign bias_due = I_LINE_PULSE & (line_cnt_q >= bias_period);

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            line_cnt_q <= 5'h00;
            bias_q     <= 1'b0;
        end else if (tft_mode) begin
            line_cnt_q <= 5'h00;
        end else if (I_LINE_PULSE) begin
            line_cnt_q <= bias_due ? 5'h00 : line_cnt_q + 5'h01;
            bias_q     <= bias_q ^ bias_due;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_FRAME_PULSE_OUT         <= 1'b0;
            O_LINE_PULSE_OUT          <= 1'b0;
            O_BIAS_OR_DATA_ENABLE_OUT <= 1'b0;
            O_PANEL_CLOCK_OUT         <= 1'b0;
        end else begin
            O_FRAME_PULSE_OUT         <= I_FRAME_PULSE ^ fp_invert;
            O_LINE_PULSE_OUT          <= I_LINE_PULSE ^ lp_invert;
            O_BIAS_OR_DATA_ENABLE_OUT <= tft_mode ? (I_DATA_ENABLE ^ oe_invert)
                                                  : bias_q;
            O_PANEL_CLOCK_OUT         <= panel_clk;
        end
    end

    // ==================================================================
    // Colour STN packer: eight 3-bit pixels become three bytes.
    pack_state_t state_q;
    pack_state_t state_d;
    logic [23:0] acc_q;
    logic [3:0]  pix_cnt_q;
    logic [1:0]  byte_cnt_q;
    logic        take_pixel;
    logic        send_byte;
    logic        last_byte;

    // A pixel is only taken while ready is shown, so a held pixel is never packed twice.
    assign take_pixel = colour_stn & (state_q == PACK_FILL) & I_PIXEL_VALID & O_PIXEL_READY;
    assign send_byte  = (state_q == PACK_SEND) & panel_rise;
    assign last_byte  = (byte_cnt_q == `BYTES_PER_GROUP - 2'h1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            PACK_FILL: begin
                if (take_pixel & (pix_cnt_q == `PIXELS_PER_GROUP - 4'h1)) begin
                    state_d = PACK_SEND;
                end
            end
            PACK_SEND: begin
                if (send_byte & last_byte) begin
                    state_d = PACK_FILL;
                end
            end
            default: begin
                state_d = PACK_FILL;
            end
        endcase
        if (!colour_stn) begin
            state_d = PACK_FILL;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_q            <= PACK_FILL;
            acc_q              <= 24'h000000;
            pix_cnt_q          <= 4'h0;
            byte_cnt_q         <= 2'h0;
            O_PANEL_DATA       <= 8'h00;
            O_PANEL_DATA_VALID <= 1'b0;
            O_PIXEL_READY      <= 1'b0;
        end else begin
            state_q            <= state_d;
            O_PANEL_DATA_VALID <= send_byte;
            // Ready drops while a group is on its way out, stalling the source.
            O_PIXEL_READY      <= colour_stn & (state_d == PACK_FILL) &
                                  ~(take_pixel & (pix_cnt_q == `PIXELS_PER_GROUP - 4'h1));
            if (!colour_stn) begin
                pix_cnt_q  <= 4'h0;
                byte_cnt_q <= 2'h0;
            end else if (take_pixel) begin
                acc_q     <= {acc_q[20:0], I_PIXEL};
                pix_cnt_q <= (pix_cnt_q == `PIXELS_PER_GROUP - 4'h1) ? 4'h0
                                                                     : pix_cnt_q + 4'h1;
            end else if (send_byte) begin
                O_PANEL_DATA <= acc_q[23:16];
                acc_q        <= {acc_q[15:0], 8'h00};
                byte_cnt_q   <= last_byte ? 2'h0 : byte_cnt_q + 2'h1;
            end
        end
    end

    // ==================================================================
    // Status read-back
    assign status_word = {24'h000000, byte_cnt_q, pix_cnt_q, O_PANEL_CLOCK_OUT, bias_q};

endmodule

// *** testbench/lcd_panel_sva.sv ***
// Checker for the panel clock block; it watches only the top-level ports.
// Assumes mode at 0x00 and the second timing register at 0x08, written over APB.
`timescale 1ns/1ps
module lcd_panel_sva (
    input wire logic        I_CLOCK,
    input wire logic        I_SYS_RST,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic        O_PREADY,
    input wire logic        I_FRAME_PULSE,
    input wire logic        I_LINE_PULSE,
    input wire logic        I_DATA_ENABLE,
    input wire logic        I_PIXEL_VALID,
    input wire logic        O_PIXEL_READY,
    input wire logic        O_FRAME_PULSE_OUT,
    input wire logic        O_BIAS_OR_DATA_ENABLE_OUT,
    input wire logic        O_PANEL_CLOCK_OUT,
    input wire logic        O_PANEL_DATA_VALID
);
    // ==========================================================
    // Shadow of the programmed fields
    logic [31:0] t2_q;
    logic [1:0]  mode_q;
    logic [4:0]  line_q;
    logic [6:0]  gap_q, quiet_q;
    logic [2:0]  pix_q;
    wire         wr   = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    wire         stn  = !mode_q[0];
    wire         turn = line_q == t2_q[10:6];
    // A write can change the divisor mid-period, so periods are judged only long after one.
    wire         calm = quiet_q > 7'h46;
    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            t2_q    <= 32'h0000_0000;
            mode_q  <= 2'h0;
            line_q  <= 5'h00;
            gap_q   <= 7'h00;
            quiet_q <= 7'h00;
            pix_q   <= 3'h0;
        end else begin
            if (wr && I_PADDR == 8'h08)
                t2_q <= I_PWDATA & 32'h07FF_7FFF;
            if (wr && I_PADDR == 8'h00)
                mode_q <= I_PWDATA[1:0];
            if (!stn || I_LINE_PULSE)
                line_q <= (!stn || turn) ? 5'h00 : line_q + 5'h01;
            gap_q   <= $rose(O_PANEL_CLOCK_OUT) ? 7'h01 : gap_q + {6'h00, gap_q != 7'h7F};
            quiet_q <= wr ? 7'h00 : quiet_q + {6'h00, quiet_q != 7'h7F};
            if (I_PIXEL_VALID && O_PIXEL_READY && mode_q == 2'h2)
                pix_q <= pix_q + 3'h1;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_SYS_RST);
    a_frame_pol: assert property (
        !$past(I_SYS_RST) |-> O_FRAME_PULSE_OUT == ($past(I_FRAME_PULSE) ^ $past(t2_q[11])))
        else $error("frame pulse polarity wrong");
    a_tft_enable: assert property (
        $past(mode_q[0]) |-> O_BIAS_OR_DATA_ENABLE_OUT == ($past(I_DATA_ENABLE) ^ $past(t2_q[14])))
        else $error("data enable output wrong");
    a_bias_turn: assert property (
        I_LINE_PULSE && stn && turn |-> ##2 $changed(O_BIAS_OR_DATA_ENABLE_OUT))
        else $error("bias did not toggle");
    a_bias_hold: assert property (
        I_LINE_PULSE && stn && !turn |-> ##2 $stable(O_BIAS_OR_DATA_ENABLE_OUT))
        else $error("bias toggled early");
    a_div_period: assert property (
        $rose(O_PANEL_CLOCK_OUT) && calm && !t2_q[5] && !(t2_q[26] && mode_q[0])
        |-> gap_q == t2_q[4:0] + 7'h02) else $error("panel clock period wrong");
    a_bypass_tick: assert property (
        t2_q[26] && mode_q[0] && !t2_q[5] && calm |-> $changed(O_PANEL_CLOCK_OUT))
        else $error("bypassed clock not toggling");
    a_byte_rise: assert property (
        O_PANEL_DATA_VALID |-> $rose(O_PANEL_CLOCK_OUT))
        else $error("byte not tied to panel clock");
    a_group_full: assert property (
        I_PIXEL_VALID && O_PIXEL_READY && mode_q == 2'h2 && pix_q == 3'h7 |=> !O_PIXEL_READY)
        else $error("ninth pixel accepted");
    c_byte: cover property ($rose(O_PANEL_DATA_VALID));
    c_bypass: cover property (t2_q[26] && mode_q[0] && calm);
    c_bias: cover property (I_LINE_PULSE && stn && turn);
endmodule

bind lcd_panel_clock_and_polarity lcd_panel_sva u_sva (
    .I_CLOCK, .I_SYS_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
    .O_PREADY, .I_FRAME_PULSE, .I_LINE_PULSE, .I_DATA_ENABLE, .I_PIXEL_VALID,
    .O_PIXEL_READY, .O_FRAME_PULSE_OUT, .O_BIAS_OR_DATA_ENABLE_OUT,
    .O_PANEL_CLOCK_OUT, .O_PANEL_DATA_VALID
);

// *** testbench/lcd_panel_model.sv ***
// Panel model: measures the panel clock period and keeps the first packed bytes.
// Assumes it is clocked by the system clock and only listens.
`timescale 1ns/1ps
module lcd_panel_model (
    input wire logic       i_clk,
    input wire logic       i_panel_clk,
    input wire logic [7:0] i_data,
    input wire logic       i_data_valid
);
    logic [7:0] gap, cyc, last, prev;
    logic [7:0] bytes [0:2];
    int         nbytes;
    initial begin
        {gap, cyc, last, prev} = '0;
        nbytes = 0;
    end
    always @(posedge i_clk) begin
        cyc  <= cyc + 8'h01;
        prev <= {7'h00, i_panel_clk};
        if (i_panel_clk && !prev[0]) begin
            gap  <= cyc - last;
            last <= cyc;
        end
        if (i_data_valid && nbytes < 3) begin
            bytes[nbytes] <= i_data;
            nbytes        <= nbytes + 1;
        end
    end
endmodule

// *** testbench/test_lcd_panel_clock_and_polarity.sv ***
// Self-checking bench for the panel clock and polarity block.
// Assumes the checker binds itself and the panel model listens on the outputs.
`timescale 1ns/1ps
module test_lcd_panel_clock_and_polarity;
    typedef struct {logic [7:0] a; logic [31:0] wd, ex; logic er;} row_t;
    logic        clk, rst, psel, penable, pwrite, ext, frame, line, de, pv, slverr, ext_on, b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rdata;
    logic [2:0]  pix;
    logic [1:0]  ediv;
    logic [4:0]  divs [0:3] = '{5'h00, 5'h01, 5'h07, 5'h1F};
    wire  [31:0] prdata;
    wire  [7:0]  pdata;
    wire         pready, pserr, prdy, fp, lp, bias, pclk, pvalid;
    int          err_count, checks_done, tog, k;
    row_t        rows [0:3] = '{'{8'h08, 32'hFFFF_FFFF, 32'h07FF_7FFF, 1'b0},
        '{8'h00, 32'hFFFF_FFFF, 32'h3, 1'b0}, '{8'h0C, 32'h5, 32'h0, 1'b1},
        '{8'h04, 32'hFFFF_FFFF, 32'h0, 1'b1}};
    lcd_panel_clock_and_polarity uut (
        .I_CLOCK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pserr), .I_EXTERNAL_CLOCK_IN(ext),
        .I_FRAME_PULSE(frame), .I_LINE_PULSE(line), .I_DATA_ENABLE(de), .I_PIXEL(pix),
        .I_PIXEL_VALID(pv), .O_PIXEL_READY(prdy), .O_FRAME_PULSE_OUT(fp),
        .O_LINE_PULSE_OUT(lp), .O_BIAS_OR_DATA_ENABLE_OUT(bias), .O_PANEL_CLOCK_OUT(pclk),
        .O_PANEL_DATA(pdata), .O_PANEL_DATA_VALID(pvalid));
    lcd_panel_model panel (.i_clk(clk), .i_panel_clk(pclk), .i_data(pdata),
        .i_data_valid(pvalid));
    always #2.5 clk = ~clk;
    // External clock rises every six system cycles while enabled.
    always @(posedge clk) begin
        if (ext_on) begin
            ediv <= (ediv == 2'h2) ? 2'h0 : ediv + 2'h1;
            ext  <= (ediv == 2'h2) ? !ext : ext;
        end
    end
    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 50);
        if (n == 50)
            err_count++;
        rdata   = prdata;
        slverr  = pserr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic gap_is(input logic [31:0] t2, input logic [31:0] exp);
        apb(8'h08, 1'b1, t2);
        repeat (100) @(posedge clk);
        check({24'h0, panel.gap}, exp);
    endtask
    // ==========================================================
    // Sequence
    initial begin
        {clk, psel, penable, pwrite, ext, frame, line, de, pv, ext_on, pix, ediv} = '0;
        {paddr, pwdata, err_count, checks_done} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(8'h08, 1'b0, 32'h0);
        check(rdata, 32'h0);
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].wd);
            check({31'h0, slverr}, {31'h0, rows[i].er});
            apb(rows[i].a, 1'b0, 32'h0);
            if (!rows[i].er)
                check(rdata, rows[i].ex);
        end
        apb(8'h08, 1'b1, 32'h0000_1800);
        repeat (3) @(posedge clk);
        check({31'h0, fp}, 32'h1);
        check({31'h0, lp}, 32'h1);
        frame <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, fp}, 32'h0);
        // TFT has no divisor minimum, so the end points 0 and 31 are legal here.
        apb(8'h00, 1'b1, 32'h1);
        foreach (divs[i])
            gap_is({27'h0, divs[i]}, {27'h0, divs[i]} + 32'h2);
        apb(8'h00, 1'b1, 32'h0);
        gap_is(32'h0400_0003, 32'h5);
        apb(8'h00, 1'b1, 32'h1);
        gap_is(32'h0400_0003, 32'h2);
        apb(8'h00, 1'b1, 32'h0);
        ext_on <= 1'b1;
        // Mono STN keeps the divisor at its single 4-bit minimum of two.
        gap_is(32'h0000_0022, 32'h18);
        ext_on <= 1'b0;
        apb(8'h00, 1'b1, 32'h1);
        apb(8'h08, 1'b1, 32'h0000_0082);
        apb(8'h00, 1'b1, 32'h0);
        repeat (3) @(posedge clk);
        b   = bias;
        tog = 0;
        repeat (6) begin
            line <= 1'b1;
            @(posedge clk);
            line <= 1'b0;
            repeat (4) @(posedge clk);
            tog += (bias !== b);
            b = bias;
        end
        check(tog, 32'h2);
        apb(8'h00, 1'b1, 32'h1);
        de <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, bias}, 32'h1);
        apb(8'h08, 1'b1, 32'h0000_4080);
        repeat (3) @(posedge clk);
        check({31'h0, bias}, 32'h0);
        de <= 1'b0;
        // Divisor four stays above the single colour minimum.
        apb(8'h08, 1'b1, 32'h4);
        apb(8'h00, 1'b1, 32'h2);
        for (int i = 0; i < 8; i++) begin
            pix <= 3'(i);
            pv  <= 1'b1;
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (!prdy && k < 100);
            if (k == 100)
                err_count++;
        end
        pv <= 1'b0;
        repeat (80) @(posedge clk);
        check({24'h0, panel.bytes[0]}, 32'h05);
        check({24'h0, panel.bytes[1]}, 32'h39);
        check({24'h0, panel.bytes[2]}, 32'h77);
        // Reset in mid-run: outputs clear, registers return to zero.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check({31'h0, fp}, 32'h0);
        rst <= 1'b0;
        apb(8'h08, 1'b0, 32'h0);
        check(rdata, 32'h0);
        repeat (2) @(posedge clk);
        check({31'h0, fp}, 32'h1);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
